// >>> core/xbp_defines.vh
// constants for the external parallel bus port: formats, strobe
// schemes and access phase lengths; included by every design file
`ifndef XBP_DEFINES_VH
`define XBP_DEFINES_VH
// address and data widths
`define XBP_ADDR_W 20
`define XBP_DATA_W 16
// bus formats (separate / multiplexed)
`define XBP_FMT_SEP 1'b0
`define XBP_FMT_MUX 1'b1
// strobe schemes
`define XBP_STB_SPLIT 1'b0
`define XBP_STB_SINGLE 1'b1
// width strap levels: low pin selects 16-bit data
`define XBP_WIDTH_16 1'b0
// phase lengths in divider pulses (address latch, strobe, recovery)
`define XBP_LATCH_CYC 3'h2
`define XBP_STROBE_CYC 3'h2
`define XBP_RECOVER_CYC 3'h1
// bus clock divider: one enable pulse every 4 clk_sys cycles
`define XBP_DIV_CYC 3'h4
`endif

// >>> core/xbp_tick.v
// divider making a one-cycle enable pulse for bus phase timing
// assumes clk_sys is the only clock
`timescale 1ns/10ps
`include "xbp_defines.vh"
module xbp_tick (
    input wire clk_sys, // system clock
    input wire rst, // async reset, active high
    output reg tick // one-cycle enable pulse
);
    reg [2:0] count; // cycles since last pulse

    // free running counter; pulse when it wraps
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count <= 3'h0;
            tick <= 1'b0;
        end else if (count == `XBP_DIV_CYC - 3'h1) begin
            count <= 3'h0;
            tick <= 1'b1;
        end else begin
            count <= count + 3'h1;
            tick <= 1'b0;
        end
    end
endmodule

// >>> core/xbp_strap.v
// catches the width and mode straps once, just after reset release
// assumes straps are steady and synchronous to clk_sys
`timescale 1ns/10ps
`include "xbp_defines.vh"
module xbp_strap (
    input wire clk_sys, // system clock
    input wire rst, // async reset, active high
    input wire bus_width_select, // strap: low = 16-bit data
    input wire processor_mode_select, // strap: high = microprocessor
    output reg wide_bus, // latched: 16-bit data bus
    output reg ext_mode, // latched: external bus enabled
    output reg strap_done // straps captured
);
    // capture on the first edge after reset; the pin must not toggle
    // later, so later changes are simply ignored
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wide_bus <= 1'b1;
            ext_mode <= 1'b0;
            strap_done <= 1'b0;
        end else if (!strap_done) begin
            wide_bus <= (bus_width_select == `XBP_WIDTH_16);
            ext_mode <= processor_mode_select;
            strap_done <= 1'b1;
        end
    end
endmodule

// >>> core/xbp_port.v
// external parallel bus port: runs one byte or word access at a time
// on the address, data, chip select and strobe pins
// assumes a single clock; all pin inputs synchronous to clk_sys
`timescale 1ns/10ps
`include "xbp_defines.vh"
// Overview of operation
// - width strap low gives 16-bit bus
// - separate format: low byte on data lines
// - separate 16-bit: high byte on own lines
// - address bits 0 to 19 driven out
// - 8-bit mux: address 0-7 then data
// - 16-bit mux: address 1-8 then data
// - four area selects identify accessed area
// - 16-bit: choose split or single strobe scheme
// - split 16-bit: low strobe writes even
// - split: high strobe writes odd address
// - read strobe low on every read
// - single scheme: store strobe on writes
// - single scheme: odd enable on odd addresses
// - address latch pulse output each access
// - release ack low while in hold
// - wait input low stretches the access
// - low reset input holds device reset
module xbp_port (
    input wire clk_sys, // system clock, 250 MHz
    input wire rst, // async reset, active high
    input wire reset_n, // external reset pin, active low
    input wire bus_width_select, // strap, low = 16-bit bus
    input wire processor_mode_select, // strap, high = microprocessor
    input wire mux_format, // 1 = address/data multiplexed
    input wire single_strobe, // 1 = store strobe + odd enable
    input wire req_valid, // access request
    input wire req_write, // 1 = write, 0 = read
    input wire req_word, // 1 = 16-bit access (wide bus only)
    input wire [19:0] req_addr, // byte address
    input wire [1:0] req_area, // area number for chip select
    input wire [15:0] req_wdata, // write data
    input wire bus_takeover_n, // hold request, active low (pulled up)
    input wire wait_insert_n, // external wait, active low
    input wire [15:0] data_in, // data pins, input side
    output reg req_ready, // idle and able to take a request
    output reg rsp_valid, // access done pulse
    output reg [15:0] rsp_rdata, // read data
    output reg wide_bus_state, // latched bus width, 1 = 16-bit
    output reg [19:0] addr_out, // address pins
    output reg [15:0] data_out, // data pins, output side
    output reg [15:0] data_oe_n, // data pin enable, low = drive
    output reg [3:0] area_select_n, // area chip selects, active low
    output reg ale, // address latch pulse, active high
    output reg read_n, // read strobe, active low
    output reg lower_byte_store_strobe_n, // store strobe / low byte
    output reg upper_byte_store_strobe_n, // odd enable / high byte
    output reg bus_release_ack_n // hold acknowledge, active low
);
    // one-hot phases: idle, latch, strobe, recovery;
    // hold is entered from idle only
    // each pin decode is then a single bit test
    localparam [4:0] S_IDLE = 5'h01; // waiting for a request
    localparam [4:0] S_LATCH = 5'h02; // address out, latch pulse
    localparam [4:0] S_STROBE = 5'h04; // strobe low, data phase
    localparam [4:0] S_RECOV = 5'h08; // strobe high, select held
    localparam [4:0] S_HOLD = 5'h10; // bus released

    // request fields copied at take; the
    // requester may change its inputs meanwhile
    // pins depend on these copies and the state
    reg [4:0] state; // one-hot state
    reg [2:0] phase_cnt; // ticks left in phase
    reg cur_write; // latched direction
    reg cur_word; // latched word access
    reg [19:0] cur_addr; // latched address
    reg [1:0] cur_area; // latched area
    reg [15:0] cur_wdata; // latched write data
    reg cur_mux; // latched format
    reg cur_single; // latched strobe scheme
    reg rst_pin_q; // sampled reset pin
    wire tick; // phase enable pulse
    wire wide_bus; // strap: 16-bit bus
    wire ext_mode; // strap: external bus enabled
    wire strap_done; // straps captured
    wire odd; // odd byte target
    wire hi_lane; // high byte moves on upper lines

    // phases last whole divider periods
    // the divider runs free from reset, so the
    // first pulse after a take comes 1 to 4 cycles
    // later; one shared counter is cheaper than a
    // counter per phase
    xbp_tick u_tick (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(tick)
    );

    // straps caught once; later changes ignored
    // width strap caught after reset
    xbp_strap u_strap (
        .clk_sys(clk_sys),
        .rst(rst),
        .bus_width_select(bus_width_select),
        .processor_mode_select(processor_mode_select),
        .wide_bus(wide_bus),
        .ext_mode(ext_mode),
        .strap_done(strap_done)
    );

    // upper lines carry a byte only on a wide bus,
    // for an odd address or a word; a narrow bus
    // always uses the low lines
    // byte lane decode used by both strobe and data logic
    function lane_hi;
        input wide;
        input a0;
        input word;
        begin
            lane_hi = wide & (a0 | word);
        end
    endfunction

    // odd byte enable covers odd bytes and words on a wide bus
    assign odd = cur_addr[0] | (wide_bus & cur_word);
    assign hi_lane = lane_hi(wide_bus, cur_addr[0], cur_word);

    // sample reset pin; it acts like a synchronous reset of the port
    // one flop of delay: the pin is taken as
    // synchronous, so a pulse under a cycle
    // may go unseen
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rst_pin_q <= 1'b0;
        end else begin
            rst_pin_q <= reset_n;
        end
    end

    // one access, in divider pulses:
    //   take: request copied, go to latch
    //   latch: address and latch pulse, 2 pulses
    //   strobe: read or store strobe, 2 pulses;
    //     a low wait input freezes the count,
    //     so a slow device stretches the phase
    //   recover: strobes high, select held 1 pulse
    //   done: response pulse, back to idle
    // read data is taken on the last strobe
    // pulse, while the read strobe is still low
    // the reset pin clears the sequencer but
    // keeps the straps; only rst recaptures them
    // hold is honoured between accesses only
    // ready returns one cycle after the response,
    // so requests never overlap
    // access sequencer; phases advance on the divider pulse
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
            phase_cnt <= 3'h0;
            cur_write <= 1'b0;
            cur_word <= 1'b0;
            cur_addr <= 20'h00000;
            cur_area <= 2'h0;
            cur_wdata <= 16'h0000;
            cur_mux <= 1'b0;
            cur_single <= 1'b1;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
        end else if (!rst_pin_q) begin
            state <= S_IDLE;
            phase_cnt <= 3'h0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= 1'b0;
            case (state)
                S_IDLE: begin
                    // ready once the straps are in, the mode
                    // strap enables the bus and no hold is asked
                    req_ready <= strap_done & ext_mode & bus_takeover_n;
                    if (!bus_takeover_n) begin
                        // the hold request is meant to stay high; if
                        // pulled low anyway, release the bus
                        state <= S_HOLD;
                        req_ready <= 1'b0;
                    end else if (req_valid && req_ready) begin
                        cur_write <= req_write;
                        cur_word <= req_word & wide_bus;
                        cur_addr <= req_addr;
                        cur_area <= req_area;
                        cur_wdata <= req_wdata;
                        cur_mux <= mux_format;
                        cur_single <= single_strobe | ~wide_bus;
                        req_ready <= 1'b0;
                        phase_cnt <= `XBP_LATCH_CYC;
                        state <= S_LATCH;
                    end
                end
                // latch: count down the address phase
                S_LATCH: begin
                    if (tick) begin
                        if (phase_cnt == 3'h1) begin
                            phase_cnt <= `XBP_STROBE_CYC;
                            state <= S_STROBE;
                        end else begin
                            phase_cnt <= phase_cnt - 3'h1;
                        end
                    end
                end
                S_STROBE: begin
                    // wait is looked at only on divider pulses;
                    // a low level between two pulses is unseen
                    // wait input stalls the phase
                    if (tick && wait_insert_n) begin
                        if (phase_cnt == 3'h1) begin
                            // a byte read comes back in the low
                            // bits, whichever lane carried it
                            if (!cur_write) begin
                                rsp_rdata <= hi_lane ?
                                    (cur_word ? data_in :
                                    {8'h00, data_in[15:8]}) :
                                    {8'h00, data_in[7:0]};
                            end
                            phase_cnt <= `XBP_RECOVER_CYC;
                            state <= S_RECOV;
                        end else begin
                            phase_cnt <= phase_cnt - 3'h1;
                        end
                    end
                end
                // recovery keeps select and address one pulse
                // after the strobes rise, then reports done
                S_RECOV: begin
                    if (tick) begin
                        rsp_valid <= 1'b1;
                        state <= S_IDLE;
                    end
                end
                // hold: bus released until the takeover input
                // is high again; no request is taken meanwhile
                S_HOLD: begin
                    if (bus_takeover_n) begin
                        state <= S_IDLE;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // pin map of one access:
    //   select, address: latch to recovery
    //   latch pulse: latch phase only
    //   muxed address: low lines, latch phase
    //   read or store strobe: strobe phase
    //   write data: strobe phase, used lanes
    // all pins trail the state by one cycle,
    // so their relative order is kept
    // data lines are released outside write
    // strobes and the muxed latch phase, so a
    // read never meets the port driving
    // selects rise one pulse after the strobes
    // so the device sees a clean end
    // pin drive, registered from state so every pin is a flop
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            addr_out <= 20'h00000;
            data_out <= 16'h0000;
            data_oe_n <= 16'hFFFF;
            area_select_n <= 4'hF;
            ale <= 1'b0;
            read_n <= 1'b1;
            lower_byte_store_strobe_n <= 1'b1;
            upper_byte_store_strobe_n <= 1'b1;
            bus_release_ack_n <= 1'b1;
            wide_bus_state <= 1'b1;
        end else begin
            wide_bus_state <= wide_bus;
            bus_release_ack_n <= ~(state == S_HOLD);
            ale <= (state == S_LATCH);
            // defaults: lines released, strobes and selects high;
            // the phase branches below override what they use
            data_oe_n <= 16'hFFFF;
            data_out <= 16'h0000;
            read_n <= 1'b1;
            lower_byte_store_strobe_n <= 1'b1;
            upper_byte_store_strobe_n <= 1'b1;
            area_select_n <= 4'hF;
            if (state == S_LATCH || state == S_STROBE ||
                state == S_RECOV) begin
                // select and address held to recovery
                area_select_n <= ~(4'h1 << cur_area);
                addr_out <= cur_addr;
            end
            if (state == S_LATCH && cur_mux) begin
                data_oe_n <= 16'hFF00;
                data_out <= wide_bus ? {8'h00, cur_addr[8:1]} :
                    {8'h00, cur_addr[7:0]};
            end
            if (state == S_STROBE) begin
                read_n <= cur_write;
                if (cur_single) begin
                    // single: one store strobe, odd enable shows lane
                    // single store strobe
                    lower_byte_store_strobe_n <= ~cur_write;
                    upper_byte_store_strobe_n <= ~odd;
                end else begin
                    // split: each strobe marks the lane it stores
                    // split strobes by lane
                    lower_byte_store_strobe_n <=
                        ~(cur_write & (~cur_addr[0] | cur_word));
                    upper_byte_store_strobe_n <= ~(cur_write & hi_lane);
                end
                if (cur_write) begin
                    // lanes not written stay released
                    // low lines, high lines when wide
                    if (cur_word) begin
                        data_out <= cur_wdata;
                        data_oe_n <= 16'h0000;
                    end else if (hi_lane) begin
                        data_out <= {cur_wdata[7:0], 8'h00};
                        data_oe_n <= 16'h00FF;
                    end else begin
                        data_out <= {8'h00, cur_wdata[7:0]};
                        data_oe_n <= 16'hFF00;
                    end
                end
            end
        end
    end
endmodule

// >>> verification/xbp_chk_chk.sv
// checker for the bus port: latch, strobe and select relations
// assumes it is bound to xbp_port and sees only its ports
`timescale 1ns/10ps
module xbp_chk (
    input wire clk_sys, // clock
    input wire rst, // reset
    input wire bus_width_select, // width strap
    input wire wait_insert_n, // wait pin
    input wire req_ready, // idle flag
    input wire rsp_valid, // done pulse
    input wire wide_bus_state, // latched width
    input wire [19:0] addr_out, // address pins
    input wire [3:0] area_select_n, // area selects
    input wire ale, // latch pulse
    input wire read_n, // read strobe
    input wire lower_byte_store_strobe_n, // low or single store strobe
    input wire upper_byte_store_strobe_n, // high strobe or odd enable
    input wire bus_release_ack_n // hold ack
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // latch phase spans two divider ticks: five to eight cycles
    sequence s_lat;
        ale [*5] ##[1:4] !ale;
    endsequence
    // any strobe; a split odd store only lowers the upper one
    sequence s_stb;
        !read_n || !lower_byte_store_strobe_n ||
            !upper_byte_store_strobe_n;
    endsequence
    property p_lat;
        $rose(ale) |-> s_lat;
    endproperty
    a_lat: assert property (p_lat) else $error("latch pulse length");
    property p_stb;
        $fell(ale) |-> ##[0:2] s_stb;
    endproperty
    a_stb: assert property (p_stb) else $error("late strobe");
    property p_hot;
        area_select_n != 4'hF |-> $onehot(~area_select_n);
    endproperty
    a_hot: assert property (p_hot) else $error("select not one-hot");
    property p_sel;
        s_stb |-> area_select_n != 4'hF && $stable(addr_out);
    endproperty
    a_sel: assert property (p_sel) else $error("select or addr moved");
    property p_wait;
        !read_n && !wait_insert_n && !$past(wait_insert_n) |=> !read_n;
    endproperty
    a_wait: assert property (p_wait) else $error("strobe left wait");
    property p_done;
        rsp_valid |-> read_n && lower_byte_store_strobe_n ##1 !rsp_valid;
    endproperty
    a_done: assert property (p_done) else $error("done with strobe low");
    property p_hold;
        !bus_release_ack_n |-> !req_ready && area_select_n == 4'hF;
    endproperty
    a_hold: assert property (p_hold) else $error("bus used in hold");
    property p_wid;
        req_ready |-> wide_bus_state == !bus_width_select;
    endproperty
    a_wid: assert property (p_wid) else $error("width state wrong");
endmodule

// >>> verification/xbp_mem.sv
// byte memory on the bus pins; answers reads at once
// assumes the bench tells it the format in use
`timescale 1ns/10ps
module xbp_mem (
    input wire clk_sys, // clock
    input wire sep16, // 16-bit separate format
    input wire single, // single strobe scheme
    input wire [19:0] addr_out, // address pins
    input wire [15:0] data_out, // data from port
    input wire read_n, // read strobe
    input wire lo_n, // low or single store strobe
    input wire hi_n, // high strobe or odd enable
    output reg [15:0] data_in // data to port
);
    reg [7:0] mem [0:511]; // byte store
    reg [15:0] last = 16'h0000; // last value on the lines
    wire [8:0] ev = {addr_out[8:1], 1'b0}; // even byte index
    wire odd = addr_out[0]; // odd address
    wire [7:0] ol = sep16 ? data_out[15:8] : data_out[7:0]; // odd lane
    // drive while read low; released lines keep changing
    always @* begin
        if (!read_n) begin
            data_in = {mem[ev + 9'h1],
                (odd && !sep16) ? mem[ev + 9'h1] : mem[ev]};
        end else begin
            data_in = ~last;
        end
    end
    always @(posedge clk_sys) begin
        last <= data_in;
        if (single && !lo_n) begin
            if (odd) mem[ev + 9'h1] <= ol;
            else mem[ev] <= data_out[7:0];
        end
        if (!single && !lo_n) mem[ev] <= data_out[7:0];
        if (!single && !hi_n) mem[ev + 9'h1] <= ol;
    end
endmodule

// >>> verification/tb_top.sv
// top bench: port with memory model on its pins, checker bound
// assumes one access at a time and straps caught at reset
`timescale 1ns/10ps
module tb_top;
    logic clk_sys, rst, reset_n, bus_width_select, processor_mode_select;
    logic mux_format, single_strobe, req_valid, req_write, req_word;
    logic bus_takeover_n, wait_insert_n, req_ready, rsp_valid, sep16;
    logic wide_bus_state, ale, read_n, lo_n, hi_n, bus_release_ack_n;
    logic [19:0] req_addr, addr_out, wa;
    logic [15:0] req_wdata, data_in, rsp_rdata, data_out, data_oe_n, wv, wo;
    logic [3:0] area_select_n, sa;
    logic [7:0] ma;
    integer n_fail, tests_run, sl, sh, sr;
    xbp_port i_dut (.clk_sys(clk_sys), .rst(rst), .reset_n(reset_n),
        .bus_width_select(bus_width_select),
        .processor_mode_select(processor_mode_select),
        .mux_format(mux_format), .single_strobe(single_strobe),
        .req_valid(req_valid), .req_write(req_write), .req_word(req_word),
        .req_addr(req_addr), .req_area(req_addr[3:2]),
        .req_wdata(req_wdata), .bus_takeover_n(bus_takeover_n),
        .wait_insert_n(wait_insert_n), .data_in(data_in),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .wide_bus_state(wide_bus_state), .addr_out(addr_out),
        .data_out(data_out), .data_oe_n(data_oe_n),
        .area_select_n(area_select_n), .ale(ale), .read_n(read_n),
        .lower_byte_store_strobe_n(lo_n), .upper_byte_store_strobe_n(hi_n),
        .bus_release_ack_n(bus_release_ack_n));
    xbp_mem i_mem (.clk_sys(clk_sys), .sep16(sep16), .single(single_strobe),
        .addr_out(addr_out), .data_out(data_out), .read_n(read_n),
        .lo_n(lo_n), .hi_n(hi_n), .data_in(data_in));
    initial begin
        clk_sys = 0;
        forever #2 clk_sys = ~clk_sys;
    end
    task step;
        @(posedge clk_sys);
        #1;
    endtask
    task chk(input bit ok, input string m);
        tests_run = tests_run + 1;
        if (!ok) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // width strap only changes while reset is held
    task do_reset(input bw);
        rst = 1;
        bus_width_select = bw;
        sep16 = !bw;
        repeat (12) @(posedge clk_sys);
        #1;
        rst = 0;
        repeat (4) step;
    endtask
    // one access; wait pin held low for wt cycles once reading
    task acc(input w, input wd, input [19:0] a, input [15:0] d, input int wt);
        int i;
        int k;
        sl = 0;
        sh = 0;
        sr = 0;
        k = 0;
        for (i = 0; i < 100 && req_ready !== 1'b1; i++) step;
        req_valid = 1;
        req_write = w;
        req_word = wd;
        req_addr = a;
        req_wdata = d;
        step;
        req_valid = 0;
        for (i = 0; i < 300; i++) begin
            step;
            if (ale === 1'b1) ma = data_out[7:0];
            if (ale === 1'b1) sa = area_select_n;
            if (lo_n === 1'b0 || hi_n === 1'b0) wo = data_oe_n;
            if (lo_n === 1'b0 || hi_n === 1'b0) wv = data_out;
            if (lo_n === 1'b0 || read_n === 1'b0) wa = addr_out;
            sl = sl + (lo_n === 1'b0);
            sh = sh + (hi_n === 1'b0);
            sr = sr + (read_n === 1'b0);
            wait_insert_n = !(sr > 0 && k < wt);
            k = k + (sr > 0);
            if (rsp_valid === 1'b1) break;
        end
        chk(i < 300, "no response");
    endtask
    task t_sep;
        acc(1, 0, 20'h12344, 16'hA5A5, 0);
        chk(sl > 0 && sh == 0 && wv[7:0] === 8'hA5, "even store");
        chk(wa === 20'h12344, "address pins");
        chk(sa === 4'hD, "area select");
        chk(wo === 16'hFF00, "low lane enable");
        acc(1, 0, 20'h12345, 16'h5A5A, 0);
        chk(sh > 0 && sl == 0 && wv[15:8] === 8'h5A, "odd store");
        chk(wo === 16'h00FF, "high lane enable");
        acc(0, 1, 20'h12344, 16'h0000, 0);
        chk(sr > 0 && rsp_rdata === 16'h5AA5, "word read");
        acc(0, 0, 20'h12345, 16'h0000, 0);
        chk(rsp_rdata[7:0] === 8'h5A, "odd byte read");
    endtask
    task t_single;
        single_strobe = 1;
        acc(1, 0, 20'h00101, 16'hC3C3, 0);
        chk(sl > 0 && sh > 0, "odd store enable");
        acc(0, 0, 20'h00100, 16'h0000, 0);
        chk(sr > 0 && sr < 16 && sh == 0 && sl == 0, "even read");
        acc(0, 0, 20'h00101, 16'h0000, 0);
        chk(sh > 0 && rsp_rdata[7:0] === 8'hC3, "odd read");
    endtask
    task t_mux;
        mux_format = 1;
        single_strobe = 0;
        sep16 = 0;
        acc(1, 0, 20'h001FE, 16'h3C3C, 0);
        chk(ma === 8'hFF && sl > 0, "mux address");
        acc(0, 0, 20'h001FE, 16'h0000, 0);
        chk(rsp_rdata[7:0] === 8'h3C, "mux data");
    endtask
    task t_wait;
        acc(0, 0, 20'h001FE, 16'h0000, 24);
        chk(sr >= 24 && rsp_rdata[7:0] === 8'h3C, "wait stretch");
    endtask
    // takeover pin kept high except in this scenario
    task t_hold;
        bus_takeover_n = 0;
        repeat (6) step;
        chk(bus_release_ack_n === 1'b0 && req_ready === 1'b0, "hold");
        bus_takeover_n = 1;
        repeat (6) step;
        chk(bus_release_ack_n === 1'b1 && req_ready === 1'b1, "resume");
    endtask
    task t_pin;
        reset_n = 0;
        repeat (3) step;
        chk(req_ready === 1'b0 && area_select_n === 4'hF, "pin reset");
        reset_n = 1;
        repeat (6) step;
        chk(req_ready === 1'b1, "pin release");
    endtask
    // single-chip start: mode strap low, width grounded
    task t_chip;
        processor_mode_select = 0;
        do_reset(0);
        chk(req_ready === 1'b0 && area_select_n === 4'hF, "chip mode");
    endtask
    task t_byte;
        processor_mode_select = 1;
        do_reset(1);
        chk(wide_bus_state === 1'b0, "narrow strap");
        // single scheme picked for the narrow bus
        single_strobe = 1;
        acc(1, 0, 20'h00037, 16'h9696, 0);
        chk(ma === 8'h37 && sl > 0 && sh > 0, "narrow store");
        acc(0, 0, 20'h00037, 16'h0000, 0);
        chk(rsp_rdata[7:0] === 8'h96, "narrow read");
    endtask
    initial begin
        #200000;
        n_fail = n_fail + 1;
        summarize;
    end
    initial begin
        n_fail = 0;
        tests_run = 0;
        reset_n = 1;
        processor_mode_select = 1;
        mux_format = 0;
        single_strobe = 0;
        req_valid = 0;
        req_write = 0;
        req_word = 0;
        req_addr = 20'h00000;
        req_wdata = 16'h0000;
        bus_takeover_n = 1;
        wait_insert_n = 1;
        do_reset(0);
        chk(wide_bus_state === 1'b1, "wide strap");
        t_sep;
        t_single;
        t_mux;
        t_wait;
        t_hold;
        t_pin;
        t_chip;
        t_byte;
        summarize;
    end
endmodule
bind xbp_port xbp_chk i_chk (.clk_sys(clk_sys), .rst(rst),
    .bus_width_select(bus_width_select), .wait_insert_n(wait_insert_n),
    .req_ready(req_ready), .rsp_valid(rsp_valid),
    .wide_bus_state(wide_bus_state), .addr_out(addr_out),
    .area_select_n(area_select_n), .ale(ale), .read_n(read_n),
    .lower_byte_store_strobe_n(lower_byte_store_strobe_n),
    .upper_byte_store_strobe_n(upper_byte_store_strobe_n),
    .bus_release_ack_n(bus_release_ack_n));
